// [src/cms_pkg.sv]
// Purpose: shared constants for the cpu mailbox and semaphore block
// Assumes: one register port per bus requester, word offsets below
// Notes: offsets are word indices on the switch core register bus
package cms_pkg;
  localparam int unsigned CMS_DATA_W = 32;
  localparam int unsigned CMS_ADDR_W = 4;
  localparam int unsigned CMS_PORTS = 4;
  localparam int unsigned CMS_OWNER_W = 3;
  // register word indices
  localparam logic [3:0] CMS_OFF_MBOX_SET = 4'h0;
  localparam logic [3:0] CMS_OFF_MBOX_CLR = 4'h1;
  localparam logic [3:0] CMS_OFF_MBOX = 4'h2;
  localparam logic [3:0] CMS_OFF_IRQ_CFG = 4'h3;
  localparam logic [3:0] CMS_OFF_TAKE0 = 4'h4;
  localparam logic [3:0] CMS_OFF_TAKE1 = 4'h5;
  localparam logic [3:0] CMS_OFF_HOLD0 = 4'h6;
  localparam logic [3:0] CMS_OFF_HOLD1 = 4'h7;
  localparam logic [3:0] CMS_OFF_FORCE = 4'h8;
  localparam logic [3:0] CMS_OFF_ROUTE = 4'h9;
  // requester ports, port 0 is the shared cpu / pcie path
  localparam int unsigned CMS_PORT_CPU = 0;
  localparam int unsigned CMS_PORT_PAR = 1;
  localparam int unsigned CMS_PORT_SER = 2;
  localparam int unsigned CMS_PORT_MGMT = 3;
  // owner field codes
  localparam logic [2:0] CMS_OWNER_FREE = 3'h0;
  localparam logic [31:0] CMS_MBOX_RST = 32'h0000_0000;
  localparam logic [31:0] CMS_ZERO = 32'h0000_0000;
endpackage : cms_pkg

// [src/cms_mailbox_sema.sv]
// Purpose: mailbox word and two hardware semaphores for cpu-to-cpu messaging
// Assumes: each requester has its own one-cycle read/write strobe port
// Notes: port 0 wins simultaneous takes; reads answer one cycle later
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - one 32-bit mailbox, readable and writable at its plain address.
// - every requester port can modify the mailbox atomically in hardware.
// - clear-address write clears exactly the mask's one bits.
// - set-address write sets exactly the mask's one bits.
// - two fully independent semaphores on the register bus.
// - any of the four register-bus requesters may own a semaphore.
// - embedded cpu and pcie host share requester port zero.
// - reading a free take register returns 1, takes it, records owner.
// - reading a held take register returns 0, owner unchanged.
// - after taking, every read returns 0 until release, owner included.
// - writing 1 to the take bit releases the semaphore.
// - release is honoured from any port, owner or not.
// - read-only holder field shows owner or free per semaphore.
// - per-semaphore soft interrupt on free or taken, by polarity bit.
// - semaphore 0 drives soft irq zero, semaphore 1 soft irq one.
// - manual trigger register asserts soft interrupts regardless of state.
// - each soft interrupt routes to embedded cpu or external output.
module cms_mailbox_sema #(
  parameter int unsigned NPORTS = cms_pkg::CMS_PORTS
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // register requests, one slot per requester port
  input wire logic [NPORTS-1:0] i_req_rd,
  input wire logic [NPORTS-1:0] i_req_wr,
  input wire logic [NPORTS*cms_pkg::CMS_ADDR_W-1:0] i_req_addr,
  input wire logic [NPORTS*cms_pkg::CMS_DATA_W-1:0] i_req_wdata,
  // read answers
  output logic [NPORTS-1:0] o_rd_valid,
  output logic [NPORTS*cms_pkg::CMS_DATA_W-1:0] o_rd_data,
  // soft interrupts
  output logic [1:0] o_soft_irq_cpu,
  output logic [1:0] o_soft_irq_ext
);
  import cms_pkg::*;

  logic [31:0] mbox_q;
  logic [31:0] mbox_d;
  logic [1:0] sema_taken_q;
  logic [1:0] sema_taken_d;
  logic [2:0] sema_owner_q [2];
  logic [2:0] sema_owner_d [2];
  logic [1:0] irq_pol_q;
  logic [1:0] irq_force_q;
  logic [1:0] irq_route_q;
  logic [1:0] soft_irq;
  logic [1:0] grant_any;
  logic [NPORTS-1:0] grant [2];
  logic [NPORTS-1:0] rd_valid_q;
  logic [31:0] rd_data_q [NPORTS];

  function automatic logic [3:0] addr_of(input logic [NPORTS*CMS_ADDR_W-1:0] a,
                                        input int unsigned p);
    addr_of = a[p*CMS_ADDR_W +: CMS_ADDR_W];
  endfunction : addr_of

  function automatic logic [31:0] wdata_of(input logic [NPORTS*CMS_DATA_W-1:0] d,
                                          input int unsigned p);
    wdata_of = d[p*CMS_DATA_W +: CMS_DATA_W];
  endfunction : wdata_of

  // mailbox: ports apply in order so two masks in one cycle both land
  always_comb begin
    mbox_d = mbox_q;
    for (int unsigned p = 0; p < NPORTS; p++) begin
      if (i_req_wr[p]) begin
        unique case (addr_of(i_req_addr, p))
          CMS_OFF_MBOX: mbox_d = wdata_of(i_req_wdata, p);
          CMS_OFF_MBOX_SET: mbox_d = mbox_d | wdata_of(i_req_wdata, p);
          CMS_OFF_MBOX_CLR: mbox_d = mbox_d & ~wdata_of(i_req_wdata, p);
          default: mbox_d = mbox_d;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mbox_q <= CMS_MBOX_RST;
    end else begin
      mbox_q <= mbox_d;
    end
  end

  // semaphores: lowest port number wins a take race; a release in the
  // same cycle as a take wins, since the releasing side intends free
  for (genvar s = 0; s < 2; s++) begin : g_sema
    always_comb begin
      logic rel;
      rel = 1'b0;
      grant[s] = '0;
      for (int unsigned p = 0; p < NPORTS; p++) begin
        if (i_req_wr[p] && addr_of(i_req_addr, p) == (CMS_OFF_TAKE0 + 4'(s))
            && i_req_wdata[p*CMS_DATA_W]) begin
          rel = 1'b1;
        end
      end
      // a reader racing a release is refused, so an answer of 1 always means ownership
      for (int unsigned p = 0; p < NPORTS; p++) begin
        if (i_req_rd[p] && addr_of(i_req_addr, p) == (CMS_OFF_TAKE0 + 4'(s))
            && !sema_taken_q[s] && !rel && grant[s] == '0) begin
          grant[s][p] = 1'b1;
        end
      end
      sema_taken_d[s] = sema_taken_q[s];
      sema_owner_d[s] = sema_owner_q[s];
      if (rel) begin
        sema_taken_d[s] = 1'b0;
        sema_owner_d[s] = CMS_OWNER_FREE;
      end else if (grant[s] != '0) begin
        sema_taken_d[s] = 1'b1;
        for (int unsigned p = 0; p < NPORTS; p++) begin
          if (grant[s][p]) begin
            sema_owner_d[s] = 3'(p + 1);
          end
        end
      end
    end
    assign grant_any[s] = |grant[s];

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        sema_taken_q[s] <= 1'b0;
        sema_owner_q[s] <= CMS_OWNER_FREE;
      end else begin
        sema_taken_q[s] <= sema_taken_d[s];
        sema_owner_q[s] <= sema_owner_d[s];
      end
    end

    // polarity 0: irq while taken, 1: irq while free
    assign soft_irq[s] = (sema_taken_q[s] ^ irq_pol_q[s]) | irq_force_q[s];
  end

  // configuration: last port in order wins a same-cycle write
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_pol_q <= 2'h0;
      irq_force_q <= 2'h0;
      irq_route_q <= 2'h0;
    end else begin
      for (int unsigned p = 0; p < NPORTS; p++) begin
        if (i_req_wr[p]) begin
          unique case (addr_of(i_req_addr, p))
            CMS_OFF_IRQ_CFG: irq_pol_q <= i_req_wdata[p*CMS_DATA_W +: 2];
            CMS_OFF_FORCE: irq_force_q <= i_req_wdata[p*CMS_DATA_W +: 2];
            CMS_OFF_ROUTE: irq_route_q <= i_req_wdata[p*CMS_DATA_W +: 2];
            default: ;
          endcase
        end
      end
    end
  end

  // route bit 0 sends to embedded cpu, 1 to the external pin
  assign o_soft_irq_cpu = soft_irq & ~irq_route_q;
  assign o_soft_irq_ext = soft_irq & irq_route_q;

  // read answers, registered; take reads see pre-cycle state
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_valid_q <= '0;
      for (int unsigned p = 0; p < NPORTS; p++) begin
        rd_data_q[p] <= CMS_ZERO;
      end
    end else begin
      rd_valid_q <= i_req_rd;
      for (int unsigned p = 0; p < NPORTS; p++) begin
        if (i_req_rd[p]) begin
          unique case (addr_of(i_req_addr, p))
            CMS_OFF_MBOX: rd_data_q[p] <= mbox_q;
            CMS_OFF_IRQ_CFG: rd_data_q[p] <= {30'h0, irq_pol_q};
            CMS_OFF_TAKE0: rd_data_q[p] <= {31'h0, grant[0][p]};
            CMS_OFF_TAKE1: rd_data_q[p] <= {31'h0, grant[1][p]};
            CMS_OFF_HOLD0: rd_data_q[p] <= {29'h0, sema_owner_q[0]};
            CMS_OFF_HOLD1: rd_data_q[p] <= {29'h0, sema_owner_q[1]};
            CMS_OFF_FORCE: rd_data_q[p] <= {30'h0, irq_force_q};
            CMS_OFF_ROUTE: rd_data_q[p] <= {30'h0, irq_route_q};
            default: rd_data_q[p] <= CMS_ZERO;
          endcase
        end
      end
    end
  end

  assign o_rd_valid = rd_valid_q;
  for (genvar p = 0; p < NPORTS; p++) begin : g_rd
    assign o_rd_data[p*CMS_DATA_W +: CMS_DATA_W] = rd_data_q[p];
  end

  // assertions
  // a take is a read that wins the grant; its answer follows one edge later
  sequence s_take0;
    grant_any[0] && !sema_taken_q[0];
  endsequence

  sequence s_take1;
    grant_any[1] && !sema_taken_q[1];
  endsequence

  sequence s_port0_won;
    grant[0][0] ##1 o_rd_valid[0];
  endsequence

  // semaphore state and ownership, interrupt lines and mailbox hold
  a_take_sets_owner: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_take0 |=> sema_taken_q[0] && sema_owner_q[0] != CMS_OWNER_FREE)
    else $error("take did not mark semaphore 0 held");
  a_take1_owner: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_take1 |=> sema_taken_q[1] && sema_owner_q[1] != CMS_OWNER_FREE)
    else $error("take did not mark semaphore 1 held");
  a_take_answer: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_port0_won |-> o_rd_data[CMS_DATA_W-1:0] == 32'h1)
    else $error("winning take did not answer one");
  a_held_read_zero: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_req_rd[0] && addr_of(i_req_addr, 0) == CMS_OFF_TAKE0 && sema_taken_q[0]
    |=> o_rd_data[CMS_DATA_W-1:0] == CMS_ZERO)
    else $error("held semaphore read did not answer zero");
  a_held0_no_grant: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sema_taken_q[0] |-> grant[0] == '0)
    else $error("held semaphore 0 granted again");
  a_grant0_needs_rd: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (grant[0] & ~i_req_rd) == '0)
    else $error("semaphore 0 granted to a port that did not read");
  a_grant1_needs_rd: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (grant[1] & ~i_req_rd) == '0)
    else $error("semaphore 1 granted to a port that did not read");
  a_rel0_frees: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sema_taken_q[0] && !sema_taken_d[0] |=> sema_owner_q[0] == CMS_OWNER_FREE)
    else $error("released semaphore 0 still shows an owner");
  a_rel1_frees: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sema_taken_q[1] && !sema_taken_d[1] |=> sema_owner_q[1] == CMS_OWNER_FREE)
    else $error("released semaphore 1 still shows an owner");
  a_owner0_range: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sema_owner_q[0] <= 3'(NPORTS))
    else $error("semaphore 0 holder code out of range");
  a_owner1_range: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sema_owner_q[1] <= 3'(NPORTS))
    else $error("semaphore 1 holder code out of range");
  a_free1_owner: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !sema_taken_q[1] |-> sema_owner_q[1] == CMS_OWNER_FREE)
    else $error("free semaphore 1 shows an owner");
  a_one_grant: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $onehot0(grant[0]) && $onehot0(grant[1]))
    else $error("semaphore granted to more than one port");
  a_held_no_grant: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sema_taken_q[1] |-> grant[1] == '0)
    else $error("held semaphore granted again");
  a_held_owner_stable: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sema_taken_q[0] && !sema_taken_d[0] == 1'b0 |=> sema_owner_q[0] == $past(sema_owner_q[0]))
    else $error("owner changed while held");
  a_free_owner_code: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !sema_taken_q[0] |-> sema_owner_q[0] == CMS_OWNER_FREE)
    else $error("free semaphore shows an owner");
  a_irq_follows: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !irq_force_q[1] && !irq_route_q[1] |-> o_soft_irq_cpu[1] == (sema_taken_q[1] ^ irq_pol_q[1]))
    else $error("soft irq one does not follow semaphore one");
  a_route_excl: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (o_soft_irq_cpu & o_soft_irq_ext) == 2'h0)
    else $error("soft irq on both destinations");
  a_force_irq: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    irq_force_q[0] |-> (o_soft_irq_cpu[0] || o_soft_irq_ext[0]))
    else $error("forced irq not asserted");
  a_mbox_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_req_wr == '0 |=> mbox_q == $past(mbox_q))
    else $error("mailbox changed without write");

  // interrupt lines, read answers and mailbox writes
  a_irq0_follows: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !irq_force_q[0] && !irq_route_q[0] |-> o_soft_irq_cpu[0] == (sema_taken_q[0] ^ irq_pol_q[0]))
    else $error("soft irq zero does not follow semaphore zero");
  a_force1_irq: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    irq_force_q[1] |-> (o_soft_irq_cpu[1] || o_soft_irq_ext[1]))
    else $error("forced irq one not asserted");
  a_ext_route1: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    irq_force_q[1] && irq_route_q[1] |-> o_soft_irq_ext[1])
    else $error("soft irq one not on the external output");
  a_irq_covers: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (o_soft_irq_cpu | o_soft_irq_ext) == soft_irq)
    else $error("soft irq lost on its way out");
  a_rd_valid_follows: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    1'b1 |=> o_rd_valid == $past(i_req_rd))
    else $error("read answer not one cycle after the request");
  a_mbox_wr_lands: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $onehot(i_req_wr) && i_req_wr[0] && addr_of(i_req_addr, 0) == CMS_OFF_MBOX
    |=> mbox_q == $past(i_req_wdata[CMS_DATA_W-1:0]))
    else $error("plain mailbox write did not land");
endmodule : cms_mailbox_sema
`default_nettype wire

// [sim/cms_tb.sv]
// Purpose: self-checking bench for the mailbox and semaphore block
// Assumes: one-cycle strobes, read answer just after the taking edge
// Notes: bench drives all four requester ports itself
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cms_pkg::*;
  logic i_sys_clk;
  logic i_nrst;
  logic [3:0] rd;
  logic [3:0] wr;
  logic [15:0] ad;
  logic [127:0] wd;
  logic [3:0] vld;
  logic [127:0] rdat;
  logic [1:0] irq_c;
  logic [1:0] irq_e;
  logic [31:0] d;
  int n_mismatch = 0;
  int checks_done = 0;
  cms_mailbox_sema #(.NPORTS(4)) i_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_req_rd(rd), .i_req_wr(wr), .i_req_addr(ad), .i_req_wdata(wd), .o_rd_valid(vld),
    .o_rd_data(rdat), .o_soft_irq_cpu(irq_c), .o_soft_irq_ext(irq_e));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // strobes rise just after one edge and drop just after the taking edge
  task automatic cyc(input logic [3:0] rm, input logic [3:0] wm);
    @(posedge i_sys_clk);
    #1;
    rd = rm;
    wr = wm;
    @(posedge i_sys_clk);
    #1;
    rd = 4'h0;
    wr = 4'h0;
    chk({28'h0, vld}, {28'h0, rm});
  endtask : cyc
  task automatic wr1(input int p, input logic [3:0] a, input logic [31:0] v);
    ad[4*p +: 4] = a;
    wd[32*p +: 32] = v;
    cyc(4'h0, 4'h1 << p);
  endtask : wr1
  task automatic rd1(input int p, input logic [3:0] a, output logic [31:0] v);
    ad[4*p +: 4] = a;
    cyc(4'h1 << p, 4'h0);
    v = rdat[32*p +: 32];
  endtask : rd1
  task automatic irq(input logic [3:0] exp);
    chk({28'h0, irq_c, irq_e}, {28'h0, exp});
  endtask : irq
  task automatic t_reset;
    rd1(0, CMS_OFF_MBOX, d);
    chk(d, CMS_MBOX_RST);
    rd1(1, CMS_OFF_HOLD0, d);
    chk(d, 32'h0);
    rd1(2, 4'hf, d);
    chk(d, 32'h0);
    irq(4'h0);
  endtask : t_reset
  task automatic t_mbox;
    wr1(2, CMS_OFF_MBOX, 32'hf0f0_1234);
    rd1(3, CMS_OFF_MBOX, d);
    chk(d, 32'hf0f0_1234);
    wr1(1, CMS_OFF_MBOX_SET, 32'h0000_0f0f);
    rd1(0, CMS_OFF_MBOX, d);
    chk(d, 32'hf0f0_1f3f);
    wr1(3, CMS_OFF_MBOX_CLR, 32'hf000_0003);
    rd1(1, CMS_OFF_MBOX, d);
    chk(d, 32'h00f0_1f3c);
    // set on port 0 and clear on port 1 land in the same cycle
    ad[7:0] = {CMS_OFF_MBOX_CLR, CMS_OFF_MBOX_SET};
    wd[63:0] = {32'h0000_0040, 32'h0000_00c0};
    cyc(4'h0, 4'h3);
    rd1(2, CMS_OFF_MBOX, d);
    chk(d, 32'h00f0_1fbc);
  endtask : t_mbox
  task automatic t_take;
    rd1(1, CMS_OFF_TAKE0, d);
    chk(d, 32'h1);
    rd1(0, CMS_OFF_HOLD0, d);
    chk(d, 32'h2);
    rd1(1, CMS_OFF_TAKE0, d);
    chk(d, 32'h0);
    rd1(2, CMS_OFF_TAKE0, d);
    chk(d, 32'h0);
    rd1(3, CMS_OFF_HOLD1, d);
    chk(d, 32'h0);
    wr1(2, CMS_OFF_TAKE0, 32'h0);
    rd1(0, CMS_OFF_HOLD0, d);
    chk(d, 32'h2);
    wr1(3, CMS_OFF_TAKE0, 32'h1);
    rd1(0, CMS_OFF_HOLD0, d);
    chk(d, 32'h0);
    rd1(3, CMS_OFF_TAKE0, d);
    chk(d, 32'h1);
    wr1(0, CMS_OFF_TAKE0, 32'h1);
  endtask : t_take
  task automatic t_race;
    ad = {4{CMS_OFF_TAKE0}};
    cyc(4'hf, 4'h0);
    chk(rdat[31:0], 32'h1);
    for (int p = 1; p < 4; p++) begin
      chk(rdat[32*p +: 32], 32'h0);
    end
    rd1(2, CMS_OFF_HOLD0, d);
    chk(d, 32'h1);
    for (int p = 0; p < 4; p++) begin
      rd1(p, CMS_OFF_TAKE1, d);
      chk(d, 32'h1);
      rd1(p, CMS_OFF_HOLD1, d);
      chk(d, 32'(p + 1));
      wr1(p, CMS_OFF_TAKE1, 32'h1);
    end
    rd1(3, CMS_OFF_TAKE1, d);
    chk(d, 32'h1);
  endtask : t_race
  // both held, polarity 0 and all routed to the cpu at first
  task automatic t_irq;
    irq(4'hc);
    wr1(1, CMS_OFF_TAKE1, 32'h1);
    irq(4'h4);
    wr1(2, CMS_OFF_IRQ_CFG, 32'h3);
    irq(4'h8);
    wr1(0, CMS_OFF_ROUTE, 32'h2);
    irq(4'h2);
    wr1(3, CMS_OFF_IRQ_CFG, 32'h0);
    wr1(1, CMS_OFF_FORCE, 32'h2);
    irq(4'h6);
    wr1(1, CMS_OFF_FORCE, 32'h0);
    irq(4'h4);
  endtask : t_irq
  task automatic close_out;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // the whole run needs some 100 cycles
  initial begin
    #(100 * 2000);
    n_mismatch++;
    close_out();
  end
  initial begin
    i_nrst = 1'b0;
    rd = 4'h0;
    wr = 4'h0;
    ad = 16'h0;
    wd = 128'h0;
    repeat (8) @(posedge i_sys_clk);
    #1;
    i_nrst = 1'b1;
    t_reset();
    t_mbox();
    t_take();
    t_race();
    t_irq();
    close_out();
  end
endmodule : tb
`default_nettype wire
